/* File: common/rct_pkg.sv */
// Package of constants and carrier types for the reload/capture timer
package rct_pkg;
  // Register byte offsets
  localparam logic [7:0]  CTRL_OFF   = 8'h00;
  localparam logic [7:0]  MODE_OFF   = 8'h04;
  localparam logic [7:0]  RELOAD_OFF = 8'h08;
  localparam logic [7:0]  COUNT_OFF  = 8'h0c;
  localparam logic [7:0]  STATUS_OFF = 8'h10;
  // Control register fields
  localparam int CTRL_RUN   = 0;
  localparam int CTRL_CT    = 1;
  localparam int CTRL_CAP   = 2;
  localparam int CTRL_EXEN  = 3;
  localparam int CTRL_TRANSMIT_CLOCK_SELECT  = 4;
  localparam int CTRL_RCLK  = 5;
  localparam int CTRL_W     = 6;
  // Mode register fields
  localparam int MODE_DOWN_COUNT_ENABLE  = 0;
  localparam int MODE_OE    = 1;
  localparam int MODE_CM_LO = 2;
  localparam int MODE_TPS_LO = 8;
  localparam int TPS_W      = 4;
  // Status register fields
  localparam int STAT_OVF   = 0;
  localparam int STAT_EXT   = 1;
  localparam int STAT_DIR   = 2;
  localparam int STAT_PIN   = 3;
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  // Count limits and dividers
  localparam logic [15:0] CNT_MIN    = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam logic [3:0]  BAUD_LAST  = 4'hf;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Auto-reload count modes
  typedef enum logic [1:0] {
    CM_RELOAD = 2'b00,
    CM_CLEAR  = 2'b01,
    CM_DUAL1  = 2'b10,
    CM_DUAL2  = 2'b11
  } rct_cm_t;

  // AXI4-Lite master to slave
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } rct_axil_req_t;

  // AXI4-Lite slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rct_axil_rsp_t;
endpackage

/* File: rtl/rct_timer.sv */
// Reload/capture timer with AXI4-Lite register access
// What this block does
// - Capture mode counts full range, overflow sets flag
// - Event pin fall captures count, sets external flag
// - Advance once per prescale plus one cycles
// - Down-count enable clears at reset
// - Mode 00 up: overflow sets flag, reloads
// - Mode 00 pin fall reloads, sets external flag
// - Mode 01 up to top, flag, back to zero
// - Mode 01 pin fall clears count, sets flag
// - Mode 01 top applied after next overflow
// - Down-count enable: pin high up, low down
// - Mode 00 down underflows at reload, loads max
// - Mode 01 up/down: top to zero, zero to top
// - Up/down toggles external flag, no interrupt
// - Modes 10/11 count up then down; no direction
// - Dual slope external flag shows direction
// - Dual slope top applied at the turn from zero
// - Mode 10 flags at zero, 11 at both
// - Serial clock select: rollover reloads from reload, mode 01 clears at top
// - Baud tick every sixteen overflows
// - Baud mode: no overflow flag, pin edge no reload
// - Clock output toggles per overflow when enabled, not with count pin
// - Count only while run control is set
module rct_timer (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire rct_pkg::rct_axil_req_t axi_req,
  output      rct_pkg::rct_axil_rsp_t axi_rsp,
  input  wire logic                   event_direction_pin,
  input  wire logic                   count_pin,
  output      logic                   clock_output_pin,
  output      logic                   baud_tick,
  output      logic                   overflow_flag,
  output      logic                   external_event_flag
);
  import rct_pkg::*;

  // Register state
  logic [CTRL_W-1:0] ctrl_q;
  logic              down_count_enable_q;
  logic              clock_output_enable_q;
  logic [1:0]        count_mode_q;
  logic [TPS_W-1:0]  prescale_select_q;
  logic [15:0]       reload_q;
  logic [15:0]       top_q;
  logic [15:0]       count_q;
  logic [15:0]       count_d;
  logic              dir_down_q;
  logic              dir_down_d;
  logic              ovf_flag_q;
  logic              ext_flag_q;
  logic              ext_flag_d;
  logic              clk_out_q;
  logic [3:0]        baud_cnt_q;
  logic              baud_tick_q;
  logic [TPS_W-1:0]  pre_cnt_q;

  // Pin synchronisers and edge history
  logic ev_s1_q, ev_s2_q, ev_s3_q;
  logic cp_s1_q, cp_s2_q, cp_s3_q;

  // Bus state
  rct_axil_rsp_t rsp_q;
  logic          aw_full_q, w_full_q;
  logic [7:0]    waddr_q;
  logic [31:0]   wdata_q;
  logic [3:0]    wstrb_q;

  // Control decode
  wire run       = ctrl_q[CTRL_RUN];
  wire ct_sel    = ctrl_q[CTRL_CT];
  wire cap_mode  = ctrl_q[CTRL_CAP];
  wire exen      = ctrl_q[CTRL_EXEN];
  wire baud_mode = ctrl_q[CTRL_TRANSMIT_CLOCK_SELECT] | ctrl_q[CTRL_RCLK];
  wire dual      = count_mode_q[1];
  wire ev_level  = ev_s2_q;
  wire ev_fall   = ev_s3_q & ~ev_s2_q;
  wire cp_fall   = cp_s3_q & ~cp_s2_q;

  // Prescaler: one step every prescale_select+1 cycles, or external falls
  wire pre_done  = (pre_cnt_q == prescale_select_q);
  wire step      = run & (ct_sel ? cp_fall : pre_done);

  // Direction: only reload modes honour the pin, dual slope keeps its own
  wire updown    = down_count_enable_q & ~cap_mode & ~baud_mode & ~dual;
  wire go_down   = updown & ~ev_level;
  wire ev_hit    = exen & ev_fall;

  // Bus write decode
  wire aw_take    = axi_req.awvalid & rsp_q.awready;
  wire w_take     = axi_req.wvalid & rsp_q.wready;
  wire wr_fire    = aw_full_q & w_full_q & ~rsp_q.bvalid;
  wire wr_ctrl    = wr_fire & (waddr_q == CTRL_OFF) & wstrb_q[0];
  wire wr_mode_lo = wr_fire & (waddr_q == MODE_OFF) & wstrb_q[0];
  wire wr_mode_hi = wr_fire & (waddr_q == MODE_OFF) & wstrb_q[1];
  wire wr_rel_lo  = wr_fire & (waddr_q == RELOAD_OFF) & wstrb_q[0];
  wire wr_rel_hi  = wr_fire & (waddr_q == RELOAD_OFF) & wstrb_q[1];
  wire wr_cnt_lo  = wr_fire & (waddr_q == COUNT_OFF) & wstrb_q[0];
  wire wr_cnt_hi  = wr_fire & (waddr_q == COUNT_OFF) & wstrb_q[1];
  wire wr_stat    = wr_fire & (waddr_q == STATUS_OFF) & wstrb_q[0];
  wire clr_ovf    = wr_stat & wdata_q[STAT_OVF];
  wire clr_ext    = wr_stat & wdata_q[STAT_EXT];
  wire wr_known   = (waddr_q == CTRL_OFF) | (waddr_q == MODE_OFF) |
                    (waddr_q == RELOAD_OFF) | (waddr_q == COUNT_OFF) |
                    (waddr_q == STATUS_OFF);

  // Bus read decode
  wire ar_take = axi_req.arvalid & rsp_q.arready;
  wire [31:0] mode_rd = {20'h00000, prescale_select_q, 4'h0, count_mode_q,
                         clock_output_enable_q, down_count_enable_q};
  wire [31:0] stat_rd = {28'h0000000, clk_out_q, dir_down_q, ext_flag_q, ovf_flag_q};
  logic [31:0] rd_data;
  logic        rd_err;
  always_comb begin
    rd_err = 1'b0;
    if (axi_req.araddr == CTRL_OFF) begin
      rd_data = {26'h0, ctrl_q};
    end else if (axi_req.araddr == MODE_OFF) begin
      rd_data = mode_rd;
    end else if (axi_req.araddr == RELOAD_OFF) begin
      rd_data = {16'h0000, reload_q};
    end else if (axi_req.araddr == COUNT_OFF) begin
      rd_data = {16'h0000, count_q};
    end else if (axi_req.araddr == STATUS_OFF) begin
      rd_data = stat_rd;
    end else begin
      rd_data = 32'h00000000;
      rd_err  = 1'b1;
    end
  end

  // Counting events, worked out for every mode from the present count
  logic rollover;   // Any overflow or underflow of the count
  logic set_ovf;
  logic set_ext;
  logic load_top;   // Take the buffered top from the reload register
  logic capture;
  always_comb begin
    count_d    = count_q;
    dir_down_d = dir_down_q;
    rollover   = 1'b0;
    set_ovf    = 1'b0;
    set_ext    = 1'b0;
    load_top   = 1'b0;
    capture    = 1'b0;
    ext_flag_d = ext_flag_q;
    if (baud_mode) begin
      // Pin edge only flags here; it is an extra event input, not a reload
      set_ext = ev_hit;
      if (step) begin
        if (count_mode_q == CM_CLEAR && count_q == top_q) begin
          count_d  = CNT_MIN;
          rollover = 1'b1;
          load_top = 1'b1;
        end else if (count_mode_q != CM_CLEAR && count_q == CNT_MAX) begin
          count_d  = reload_q;
          rollover = 1'b1;
        end else begin
          count_d = count_q + 16'h0001;
        end
      end
    end else if (cap_mode) begin
      if (ev_hit) begin
        capture = 1'b1;
        set_ext = 1'b1;
      end
      if (step) begin
        count_d = count_q + 16'h0001;
        if (count_q == CNT_MAX) begin
          rollover = 1'b1;
          set_ovf  = 1'b1;
        end
      end
    end else if (dual) begin
      // Dual slope: the flag mirrors direction and the pin is ignored
      if (step) begin
        if (!dir_down_q) begin
          if (count_q >= top_q) begin
            dir_down_d = 1'b1;
            count_d    = (top_q == CNT_MIN) ? CNT_MIN : count_q - 16'h0001;
            rollover   = 1'b1;
            set_ovf    = (count_mode_q == CM_DUAL2);
          end else begin
            count_d = count_q + 16'h0001;
          end
        end else begin
          if (count_q == CNT_MIN) begin
            dir_down_d = 1'b0;
            count_d    = CNT_MIN + 16'h0001;
            rollover   = 1'b1;
            set_ovf    = 1'b1;
            load_top   = 1'b1;
          end else begin
            count_d = count_q - 16'h0001;
          end
        end
      end
      ext_flag_d = dir_down_d;
    end else if (count_mode_q == CM_RELOAD) begin
      if (step) begin
        if (go_down) begin
          if (count_q == reload_q) begin
            count_d  = CNT_MAX;
            rollover = 1'b1;
            set_ovf  = 1'b1;
          end else begin
            count_d = count_q - 16'h0001;
          end
        end else if (count_q == CNT_MAX) begin
          count_d  = reload_q;
          rollover = 1'b1;
          set_ovf  = 1'b1;
        end else begin
          count_d = count_q + 16'h0001;
        end
      end
      if (ev_hit && !updown) begin
        count_d = reload_q;
        set_ext = 1'b1;
      end
    end else begin
      if (step) begin
        if (go_down) begin
          if (count_q == CNT_MIN) begin
            count_d  = top_q;
            rollover = 1'b1;
            set_ovf  = 1'b1;
          end else begin
            count_d = count_q - 16'h0001;
          end
        end else if (count_q >= top_q) begin
          count_d  = CNT_MIN;
          rollover = 1'b1;
          set_ovf  = 1'b1;
          load_top = 1'b1;
        end else begin
          count_d = count_q + 16'h0001;
        end
      end
      if (ev_hit && !updown) begin
        count_d = CNT_MIN;
        set_ext = 1'b1;
      end
    end
    // Up/down: flag becomes a 17th count bit
    if (updown && rollover) begin
      ext_flag_d = ~ext_flag_q;
    end else if (!dual || baud_mode || cap_mode) begin
      // Hardware set wins over a software clear in the same cycle
      ext_flag_d = (ext_flag_q & ~clr_ext) | set_ext;
    end
  end

  // Input synchronisers; the third stage only serves edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {ev_s1_q, ev_s2_q, ev_s3_q} <= 3'h7;
      {cp_s1_q, cp_s2_q, cp_s3_q} <= 3'h7;
    end else begin
      {ev_s1_q, ev_s2_q, ev_s3_q} <= {event_direction_pin, ev_s1_q, ev_s2_q};
      {cp_s1_q, cp_s2_q, cp_s3_q} <= {count_pin, cp_s1_q, cp_s2_q};
    end
  end

  // Prescaler counter; held at zero while stopped so the first step is full length
  always_ff @(posedge aclk) begin
    if (!aresetn || !run || pre_done || ct_sel) begin
      pre_cnt_q <= '0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 1'b1;
    end
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q                <= CTRL_RST;
      down_count_enable_q   <= 1'b0;
      clock_output_enable_q <= 1'b0;
      count_mode_q          <= CM_RELOAD;
      prescale_select_q     <= '0;
    end else begin
      if (wr_ctrl) ctrl_q <= wdata_q[CTRL_W-1:0];
      if (wr_mode_lo) begin
        down_count_enable_q   <= wdata_q[MODE_DOWN_COUNT_ENABLE];
        clock_output_enable_q <= wdata_q[MODE_OE];
        count_mode_q          <= wdata_q[MODE_CM_LO +: 2];
      end
      if (wr_mode_hi) prescale_select_q <= wdata_q[MODE_TPS_LO +: TPS_W];
    end
  end

  // Reload/capture register; a hardware capture beats a software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_q <= RELOAD_RST;
    end else if (capture) begin
      reload_q <= count_q;
    end else begin
      if (wr_rel_lo) reload_q[7:0]  <= wdata_q[7:0];
      if (wr_rel_hi) reload_q[15:8] <= wdata_q[15:8];
    end
  end

  // Active top: double-buffered copy of the reload register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      top_q <= RELOAD_RST;
    end else if (load_top || !run) begin
      top_q <= reload_q;
    end
  end

  // Count, direction and flags; software count writes take precedence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q    <= CNT_MIN;
      dir_down_q <= 1'b0;
      ovf_flag_q <= 1'b0;
      ext_flag_q <= 1'b0;
    end else begin
      count_q <= count_d;
      if (wr_cnt_lo) count_q[7:0]  <= wdata_q[7:0];
      if (wr_cnt_hi) count_q[15:8] <= wdata_q[15:8];
      dir_down_q <= dir_down_d;
      ovf_flag_q <= (ovf_flag_q & ~clr_ovf) | set_ovf;
      ext_flag_q <= ext_flag_d;
    end
  end

  // Clock output and baud tick, both driven by rollovers only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_out_q   <= 1'b0;
      baud_cnt_q  <= 4'h0;
      baud_tick_q <= 1'b0;
    end else begin
      if (rollover && clock_output_enable_q && !ct_sel) begin
        clk_out_q <= ~clk_out_q;
      end
      baud_tick_q <= baud_mode & rollover & (baud_cnt_q == BAUD_LAST);
      if (!baud_mode) begin
        baud_cnt_q <= 4'h0;
      end else if (rollover) begin
        baud_cnt_q <= baud_cnt_q + 4'h1;
      end
    end
  end

  // AXI4-Lite write channels; address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      waddr_q       <= 8'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      rsp_q.awready <= 1'b0;
      rsp_q.wready  <= 1'b0;
      rsp_q.bvalid  <= 1'b0;
      rsp_q.bresp   <= RESP_OKAY;
    end else begin
      if (aw_take) waddr_q <= {axi_req.awaddr[7:2], 2'b00};
      if (w_take) begin
        wdata_q <= axi_req.wdata;
        wstrb_q <= axi_req.wstrb;
      end
      aw_full_q     <= ~wr_fire & (aw_full_q | aw_take);
      w_full_q      <= ~wr_fire & (w_full_q | w_take);
      rsp_q.awready <= ~(~wr_fire & (aw_full_q | aw_take));
      rsp_q.wready  <= ~(~wr_fire & (w_full_q | w_take));
      if (wr_fire) begin
        rsp_q.bvalid <= 1'b1;
        rsp_q.bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (axi_req.bready) begin
        rsp_q.bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channels; one read outstanding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp_q.arready <= 1'b0;
      rsp_q.rvalid  <= 1'b0;
      rsp_q.rdata   <= 32'h00000000;
      rsp_q.rresp   <= RESP_OKAY;
    end else if (ar_take) begin
      rsp_q.arready <= 1'b0;
      rsp_q.rvalid  <= 1'b1;
      rsp_q.rdata   <= rd_data;
      rsp_q.rresp   <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rsp_q.rvalid && axi_req.rready) begin
      rsp_q.rvalid  <= 1'b0;
      rsp_q.arready <= 1'b1;
    end else if (!rsp_q.rvalid) begin
      rsp_q.arready <= 1'b1;
    end
  end

  // Outputs straight from flip-flops
  assign axi_rsp             = rsp_q;
  assign clock_output_pin    = clk_out_q;
  assign baud_tick           = baud_tick_q;
  assign overflow_flag       = ovf_flag_q;
  assign external_event_flag = ext_flag_q;
endmodule

/* File: verif/rct_timer_properties.sv */
// Port-level assertions for the reload/capture timer
module rct_timer_properties (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire rct_pkg::rct_axil_req_t axi_req,
  input wire rct_pkg::rct_axil_rsp_t axi_rsp,
  input wire logic                   clock_output_pin,
  input wire logic                   baud_tick,
  input wire logic                   overflow_flag,
  input wire logic                   external_event_flag
);
  import rct_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [7:0] gap_q;
  logic       setup_q;
  // Handshakes that start a write or a read
  wire        w_take = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  wire        r_take = axi_req.arvalid && axi_rsp.arready;
  // Cycles since the last serial tick; saturates so a first tick never looks early
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_q   <= 8'hff;
      setup_q <= 1'b0;
    end else begin
      gap_q   <= baud_tick ? 8'h01 : (gap_q == 8'hff ? gap_q : gap_q + 8'h01);
      setup_q <= setup_q | (axi_req.awvalid & axi_rsp.awready);
    end
  end
  a_quiet_until_setup: assert property (
    !setup_q |-> !overflow_flag && !external_event_flag && !clock_output_pin && !baud_tick)
    else $error("output moved before any register write");
  a_baud_single: assert property (
    baud_tick |=> !baud_tick) else $error("serial tick longer than one cycle");
  a_baud_spacing: assert property (
    baud_tick |-> gap_q >= 8'h10) else $error("serial ticks closer than sixteen rollovers");
  a_read_next: assert property (
    r_take |=> axi_rsp.rvalid) else $error("read answer late");
  a_read_unmapped: assert property (
    r_take && axi_req.araddr > STATUS_OFF |=> axi_rsp.rresp == RESP_SLVERR
      && axi_rsp.rdata == 32'h0) else $error("unmapped read not refused");
  a_read_holds: assert property (
    axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped early");
  a_write_holds: assert property (
    axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped early");
  a_write_answer: assert property (
    w_take |-> ##[1:3] axi_rsp.bvalid) else $error("write response missing");
  c_overflow: cover property ($rose(overflow_flag));
  c_event: cover property ($rose(external_event_flag));
  c_baud: cover property (baud_tick);
endmodule

bind rct_timer rct_timer_properties rct_timer_properties_inst (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .clock_output_pin(clock_output_pin), .baud_tick(baud_tick),
  .overflow_flag(overflow_flag), .external_event_flag(external_event_flag)
);

/* File: verif/rct_pin_model.sv */
// Far-side model: event pin, count pin, clock-out and serial tick observer
module rct_pin_model (
  input  wire logic        aclk,
  input  wire logic        pulse_go,
  input  wire logic        dir_up,
  input  wire logic        clock_output_pin,
  input  wire logic        baud_tick,
  output      logic        event_direction_pin,
  output      logic        count_pin,
  output      logic [31:0] clk_gap,
  output      logic [31:0] baud_gap
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] ccnt     = 32'h0;
  logic [31:0] bcnt     = 32'h0;
  logic [1:0]  low_left = 2'h0;
  logic        clk_last = 1'b0;
  // Pin stays low three cycles so both levels outlast the synchronizer
  assign event_direction_pin = dir_up && (low_left == 2'h0);
  assign count_pin           = bcnt[1];
  // Interval between clock-out toggles and between serial ticks
  always @(posedge aclk) begin
    low_left <= pulse_go ? 2'h3 : (low_left == 2'h0 ? low_left : low_left - 2'h1);
    clk_last <= clock_output_pin;
    ccnt     <= (clock_output_pin != clk_last) ? 32'h1 : ccnt + 32'h1;
    bcnt     <= baud_tick ? 32'h1 : bcnt + 32'h1;
    if (clock_output_pin != clk_last) clk_gap <= ccnt;
    if (baud_tick) baud_gap <= bcnt;
  end
endmodule

/* File: verif/tb_reload_capture_timer.sv */
// Self-checking bench for the reload/capture timer
module tb_reload_capture_timer;
  timeunit 1ns;
  timeprecision 1ns;
  import rct_pkg::*;
  localparam logic [31:0] RUN  = 32'h1 << CTRL_RUN;
  localparam logic [31:0] CT   = 32'h1 << CTRL_CT;
  localparam logic [31:0] CAP  = 32'h1 << CTRL_CAP;
  localparam logic [31:0] EXEN = 32'h1 << CTRL_EXEN;
  localparam logic [31:0] TRANSMIT_CLOCK_SELECT = 32'h1 << CTRL_TRANSMIT_CLOCK_SELECT;
  localparam logic [31:0] EV_CTRL [5] = '{CAP | EXEN, EXEN, EXEN, TRANSMIT_CLOCK_SELECT | EXEN, 32'h0};
  logic          aclk      = 1'b0;
  logic          aresetn   = 1'b0;
  logic          pulse_go  = 1'b0;
  logic          dir_up    = 1'b1;
  rct_axil_req_t req       = '0;
  rct_axil_rsp_t rsp;
  logic          clock_output_pin, baud_tick, overflow_flag, external_event_flag;
  logic          event_direction_pin, count_pin;
  logic [31:0]   clk_gap, baud_gap;
  logic [31:0]   rd_q[$];
  logic [1:0]    rs_q[$], bs_q[$];
  logic [15:0]   rnd       = 16'h100b;
  int            bad_count = 0;
  int            n_tests   = 0;
  wire  [2:0]    obs       = {external_event_flag, overflow_flag, clock_output_pin};

  // 50 MHz clock
  initial forever #10 aclk = ~aclk;

  rct_timer rct_timer_inst (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .event_direction_pin(event_direction_pin), .count_pin(count_pin),
    .clock_output_pin(clock_output_pin), .baud_tick(baud_tick),
    .overflow_flag(overflow_flag), .external_event_flag(external_event_flag));
  rct_pin_model rct_pin_model_inst (.aclk(aclk), .pulse_go(pulse_go), .dir_up(dir_up),
    .clock_output_pin(clock_output_pin), .baud_tick(baud_tick),
    .event_direction_pin(event_direction_pin), .count_pin(count_pin),
    .clk_gap(clk_gap), .baud_gap(baud_gap));

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Mode word with the clock output always enabled
  function automatic logic [31:0] mw(input logic dc, input logic [1:0] cm, input logic [3:0] ps);
    return (32'(ps) << MODE_TPS_LO) | (32'(cm) << MODE_CM_LO) | (32'h1 << MODE_OE) | 32'(dc);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic over(input logic hit);
    if (hit) begin
      bad_count++;
      $display("[FAIL] %0t wait ran out", $time);
      summarize();
    end
  endtask
  task automatic wait_obs(input int s, input logic v);
    int i;
    for (i = 0; i < 3000 && obs[s] !== v; i++) @(posedge aclk);
    over(i >= 3000);
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int   i;
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    bs_q.push_back(a[7:2] <= 6'h04 ? RESP_OKAY : RESP_SLVERR);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    for (i = 0; i < 50 && (pa || pw); i++) begin
      @(posedge aclk);
      if (pa && rsp.awready) begin
        pa = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (pw && rsp.wready) begin
        pw = 1'b0;
        req.wvalid <= 1'b0;
      end
    end
    for (; i < 100 && rsp.bvalid !== 1'b1; i++) @(posedge aclk);
    over(i >= 100);
    req.bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    int i;
    rd_q.push_back(e);
    rs_q.push_back(a <= STATUS_OFF && a[1:0] == 2'b00 ? RESP_OKAY : RESP_SLVERR);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    // Address stays offered until the edge that takes it, and not one edge longer
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (rsp.arready === 1'b1) break;
    end
    req.arvalid <= 1'b0;
    for (; i < 100 && rsp.rvalid !== 1'b1; i++) @(posedge aclk);
    over(i >= 100);
    req.rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Restart from a clean state, then let n clock-out toggles pass so the gap is a full one
  task automatic run(input logic [31:0] ct, md, rl, cn, input int n);
    wr(CTRL_OFF, 32'h0);
    wr(STATUS_OFF, 32'h3);
    wr(MODE_OFF, md);
    wr(RELOAD_OFF, rl);
    wr(COUNT_OFF, cn);
    wr(CTRL_OFF, ct | RUN);
    repeat (n) begin
      wait_obs(0, ~obs[0]);
      @(posedge aclk);
    end
  endtask

  // Each response handshake takes the oldest expectation
  always @(posedge aclk) begin
    if (rsp.rvalid && req.rready) begin
      check(rsp.rdata, rd_q.pop_front());
      check(32'(rsp.rresp), 32'(rs_q.pop_front()));
    end
    if (rsp.bvalid && req.bready) check(32'(rsp.bresp), 32'(bs_q.pop_front()));
  end

  // Main sequence
  initial begin
    logic [15:0] c, r;
    int          k, p;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (k = 0; k <= 16; k += 4) rd(8'(k), 32'h0);
    rd(8'h14, 32'h0);
    wr(8'h20, 32'h1);
    // Pin fall while stopped: capture, reload, clear, serial mode, disabled
    for (k = 0; k < 5; k++) begin
      rnd = lfsr(rnd);
      c = rnd;
      rnd = lfsr(rnd);
      r = rnd;
      wr(CTRL_OFF, EV_CTRL[k]);
      wr(MODE_OFF, mw(1'b0, {1'b0, k == 2}, 4'h0));
      wr(RELOAD_OFF, 32'(r));
      wr(COUNT_OFF, 32'(c));
      pulse_go <= 1'b1;
      @(posedge aclk);
      pulse_go <= 1'b0;
      repeat (8) @(posedge aclk);
      check(32'(external_event_flag), 32'(k != 4));
      rd(k ? COUNT_OFF : RELOAD_OFF, 32'(k == 1 ? r : (k == 2 ? 16'h0 : c)));
      wr(STATUS_OFF, 32'h3);
    end
    // Up count near the top with a random reload and prescale
    rnd = lfsr(rnd);
    r = 16'hffe0 | 16'(rnd[4:0]);
    run(32'h0, mw(1'b0, 2'b00, 4'(rnd[6:5])), 32'(r), 32'(r), 3);
    check(clk_gap, (32'h10000 - 32'(r)) * (32'(rnd[6:5]) + 32'h1));
    check(32'(overflow_flag), 32'h1);
    // Capture mode wraps to zero, not to the reload value; slow prescale keeps it there
    run(CAP, mw(1'b0, 2'b00, 4'hf), 32'h8000, 32'hfffe, 0);
    wait_obs(1, 1'b1);
    wr(CTRL_OFF, 32'h0);
    rd(COUNT_OFF, 32'h0);
    // Direction pin low: down counting where enabled, ignored in dual slope
    dir_up <= 1'b0;
    r = 16'h0010 | 16'(rnd[10:7]);
    run(32'h0, mw(1'b1, 2'b00, 4'h0), 32'hffe0, 32'hffe8, 3);
    check(clk_gap, 32'h20);
    check(32'(overflow_flag), 32'h1);
    wait_obs(2, ~obs[2]);
    for (k = 0; k < 2; k++) begin
      run(32'h0, mw(1'(k), 2'b01, 4'h0), 32'(r), 32'h0, 3);
      check(clk_gap, 32'(r) + 32'h1);
    end
    wait_obs(2, ~obs[2]);
    for (k = 2; k < 4; k++) begin
      run(32'h0, mw(1'b1, 2'(k), 4'h0), 32'h40, 32'h0, 0);
      wait_obs(2, 1'b1);
      wait_obs(2, 1'b0);
      repeat (2) @(posedge aclk);
      wr(STATUS_OFF, 32'h1);
      wait_obs(2, 1'b1);
      @(posedge aclk);
      check(32'(overflow_flag), 32'(k == 3));
      wait_obs(2, 1'b0);
      for (p = 0; p < 3000 && !obs[2]; p++) @(posedge aclk);
      for (; p < 3000 && obs[2]; p++) @(posedge aclk);
      check(32'(p), 32'h80);
    end
    dir_up <= 1'b1;
    // Serial rate mode: reload on rollover, no overflow flag
    run(TRANSMIT_CLOCK_SELECT, mw(1'b0, 2'b00, 4'h0), 32'hfffc, 32'hfffc, 3);
    repeat (140) @(posedge aclk);
    check(clk_gap, 32'h4);
    check(baud_gap, 32'h40);
    check(32'(overflow_flag), 32'h0);
    // External count input: still rolls over, but the clock output must stay still
    run(CT, mw(1'b0, 2'b00, 4'h0), 32'hfff0, 32'hfff0, 0);
    p = 32'(clock_output_pin);
    wait_obs(1, 1'b1);
    check(32'(clock_output_pin), 32'(p));
    summarize();
  end
endmodule
